/* File: rtl/flash_volcfg_cfg.svh */
`ifndef FLASH_VOLCFG_CFG_SVH
`define FLASH_VOLCFG_CFG_SVH

// volatile read config field positions
`define VRC_DUMMY_HI     7
`define VRC_DUMMY_LO     4
`define VRC_XIP_BIT      3
`define VRC_KEEP_MASK    8'hF8
// volatile enhanced config field positions
`define VEC_QUAD_BIT     7
`define VEC_DUAL_BIT     6
`define VEC_HOLD_BIT     4
`define VEC_ACCEL_BIT    3
`define VEC_DRV_HI       2
`define VEC_DRV_LO       0
`define VEC_KEEP_MASK    8'hDF
// nonvolatile config field positions
`define NV_DUMMY_HI      15
`define NV_DUMMY_LO      12
`define NV_XIP_HI        11
`define NV_XIP_LO        9
`define NV_DRV_HI        8
`define NV_DRV_LO        6
`define NV_HOLD_BIT      4
`define NV_QUAD_BIT      3
`define NV_DUAL_BIT      2
`define NV_XIP_OFF       3'h7
// reset values
`define VRC_RESET        8'hF8
`define VEC_RESET        8'hDF
`define DUMMY_CODE_ZERO  4'h0
`define DUMMY_DEFAULT    4'hF
// output impedance in ohms per driver code
`define DRV_CODE_60      3'h2
`define DRV_CODE_45      3'h3
`define DRV_CODE_20      3'h5
`define DRV_CODE_15      3'h6
`define DRV_CODE_30      3'h7
`define DRV_OHMS_60      6'h3C
`define DRV_OHMS_45      6'h2D
`define DRV_OHMS_20      6'h14
`define DRV_OHMS_15      6'h0F
`define DRV_OHMS_30      6'h1E
`define DRV_OHMS_NONE    6'h00

`endif

/* File: rtl/flash_volcfg_pkg.sv */
package flash_volcfg_pkg;

  // command protocol currently in force
  typedef enum logic [2:0] {
    PROTO_EXTENDED = 3'b001,
    PROTO_DUAL     = 3'b010,
    PROTO_QUAD     = 3'b100
  } proto_t;

  // instruction tracking states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0001,
    ST_WAIT_DATA = 4'b0010,
    ST_WAIT_END  = 4'b0100,
    ST_READ      = 4'b1000
  } instr_state_t;

endpackage : flash_volcfg_pkg

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // system clock
  input  wire logic             resetn, // async reset, active low
  input  wire logic [WIDTH-1:0] d,      // asynchronous pin levels
  input  wire logic [WIDTH-1:0] init,   // constant idle level
  output logic      [WIDTH-1:0] q       // synchronised levels
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] hold_reg;

  // two flops per pin, first stage read only by second; both hold the
  // offset from the idle level so reset shows idle and no false edge follows
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      hold_reg <= '0;
    end else begin
      meta_reg <= d ^ init;
      hold_reg <= meta_reg;
    end
  end

  // undo the idle offset
  assign q = hold_reg ^ init;

endmodule : pin_sync

/* File: rtl/dummy_counter.sv */
`timescale 1ns/1ps

module dummy_counter (
  input  wire logic       clk,        // system clock
  input  wire logic       resetn,     // async reset, active low
  input  wire logic       start,      // begin dummy phase
  input  wire logic       tick,       // serial clock rising edge
  input  wire logic       abort,      // deselect ends the phase
  input  wire logic [3:0] count,      // dummy clocks to insert
  output logic            active,     // dummy phase running
  output logic            first_tick, // first dummy clock edge
  output logic            done        // pulse after last dummy clock
);

  logic [3:0] left_reg;
  logic [3:0] len_reg;

  assign first_tick = active && tick && (left_reg == len_reg);

  // count serial clock edges down to zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active   <= 1'b0;
      done     <= 1'b0;
      left_reg <= 4'h0;
      len_reg  <= 4'h0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        active <= 1'b0;
      end else if (start) begin
        active   <= 1'b1;
        left_reg <= count;
        len_reg  <= count;
      end else if (active && tick) begin
        left_reg <= left_reg - 4'h1;
        if (left_reg == 4'h1) begin
          active <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

endmodule : dummy_counter

/* File: rtl/flash_volcfg.sv */
`timescale 1ns/1ps
`include "flash_volcfg_cfg.svh"

// Functional notes
// - completed write-read-config instruction replaces dummy and xip settings at once
// - dummy field codes 1..14 give that count; codes 0 and 15 give 15
// - dummy count applies to all fast reads and the otp area read
// - read config bit 3 low readies xip; high (default) disables it
// - with xip readied, line zero is sampled on the first dummy clock
// - basic xip variant ignores bit 3 and always permits xip
// - completed write-enhanced-config instruction replaces protocol, hold, accel, drive
// - enhanced bit 7 low selects quad protocol; default high keeps extended
// - enhanced bit 6 low selects dual protocol; default high disables it
// - both select bits low gives quad protocol
// - bit 7 back high returns to extended, or dual if bit 6 low
// - enhanced bit 4 low disables hold/reset pin function
// - enhanced bit 3 low enables accelerator only for quad programs or quad protocol
// - enhanced bits 2..0 encode driver impedance; 000, 001 and 100 reserved
// - power-on loads defaults from nonvolatile config before any volatile write
module flash_volcfg
  import flash_volcfg_pkg::*;
#(
  parameter logic [7:0] OP_WR_VRC    = 8'h01, // arbitrary opcode values
  parameter logic [7:0] OP_WR_VEC    = 8'h02,
  parameter logic [7:0] OP_RD_SINGLE = 8'h03,
  parameter logic [7:0] OP_RD_DOUT   = 8'h04,
  parameter logic [7:0] OP_RD_DIO    = 8'h05,
  parameter logic [7:0] OP_RD_QOUT   = 8'h06,
  parameter logic [7:0] OP_RD_QIO    = 8'h07,
  parameter logic [7:0] OP_RD_OTP    = 8'h08,
  parameter logic [7:0] OP_PG_QUAD   = 8'h09,
  parameter logic [7:0] OP_PG_QEXT   = 8'h0A,
  parameter bit         BASIC_XIP    = 1'b0   // basic xip variant
) (
  input  wire logic                     clk,              // 25 MHz system clock
  input  wire logic                     resetn,           // async reset, active low
  input  wire logic [15:0]              nv_config,        // nonvolatile config contents
  input  wire logic                     instr_valid,      // decoded opcode strobe
  input  wire logic [7:0]               instr_code,       // decoded opcode
  input  wire logic                     data_valid,       // data byte strobe
  input  wire logic [7:0]               data_byte,        // received data byte
  input  wire logic                     addr_done,        // address phase finished
  input  wire logic                     sclk_pin,         // serial clock pin
  input  wire logic                     chip_select_n,    // chip select pin, active low
  input  wire logic                     serial_io_line_zero, // data line zero pin
  output logic [7:0]                    volatile_read_config,     // read config readback
  output logic [7:0]                    volatile_enhanced_config, // enhanced readback
  output logic [3:0]                    dummy_cycles,     // effective dummy count
  output logic                          dummy_phase,      // dummy clocks in progress
  output logic                          read_data_start,  // pulse: dummy phase over
  output logic                          xip_ready,        // xip entry permitted
  output logic                          xip_sample_valid, // pulse: line zero captured
  output logic                          xip_line_value,   // line zero at first dummy
  output flash_volcfg_pkg::proto_t      protocol,         // command protocol
  output logic                          hold_enable,      // hold/reset pin active
  output logic                          accel_enable,     // accelerator voltage allowed
  output logic [2:0]                    drive_code,       // driver strength code
  output logic [5:0]                    drive_ohms,       // impedance in ohms
  output logic                          drive_reserved    // code is reserved
);

  instr_state_t state_reg;
  logic [7:0]   vrc_reg;
  logic [7:0]   vec_reg;
  logic [7:0]   stage_reg;
  logic         target_vec_reg;
  logic         por_done_reg;
  logic         qprog_reg;
  logic [2:0]   pins_s;
  logic         sclk_s;
  logic         cs_n_s;
  logic         dq0_s;
  logic         sclk_prev_reg;
  logic         cs_prev_reg;
  logic         sclk_rise;
  logic         cs_rise;
  logic         commit;
  logic         is_fast_read;
  logic         is_quad_prog;
  logic         cnt_active;
  logic         cnt_first;
  logic         cnt_done;
  logic [3:0]   dummy_code;

  // bring serial pins into the clock domain
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({sclk_pin, chip_select_n, serial_io_line_zero}),
    .init   (3'h2),
    .q      (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign dq0_s  = pins_s[0];

  // edge history of synchronised pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg   <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_prev_reg;
  assign cs_rise   = cs_n_s && !cs_prev_reg;
  assign commit    = (state_reg == ST_WAIT_END) && cs_rise;

  // opcode classes
  assign is_fast_read = (instr_code == OP_RD_SINGLE) || (instr_code == OP_RD_DOUT) ||
                        (instr_code == OP_RD_DIO) || (instr_code == OP_RD_QOUT) ||
                        (instr_code == OP_RD_QIO) || (instr_code == OP_RD_OTP);
  assign is_quad_prog = (instr_code == OP_PG_QUAD) || (instr_code == OP_PG_QEXT);

  // instruction tracking; a write only counts once deselect ends it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= ST_IDLE;
      stage_reg      <= 8'h00;
      target_vec_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (instr_valid && !cs_n_s && por_done_reg) begin
            if (instr_code == OP_WR_VRC || instr_code == OP_WR_VEC) begin
              state_reg      <= ST_WAIT_DATA;
              target_vec_reg <= (instr_code == OP_WR_VEC);
            end else if (is_fast_read) begin
              state_reg <= ST_READ;
            end
          end
        end
        ST_WAIT_DATA: begin
          if (cs_rise) begin
            state_reg <= ST_IDLE;
          end else if (data_valid) begin
            stage_reg <= data_byte;
            state_reg <= ST_WAIT_END;
          end
        end
        ST_WAIT_END: begin
          if (cs_rise) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_READ: begin
          if (cs_rise) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // power-on load, then volatile overrides; reserved bits stored as zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      por_done_reg <= 1'b0;
      vrc_reg      <= `VRC_RESET;
      vec_reg      <= `VEC_RESET;
    end else if (!por_done_reg) begin
      por_done_reg <= 1'b1;
      vrc_reg      <= {nv_config[`NV_DUMMY_HI:`NV_DUMMY_LO],
                       nv_config[`NV_XIP_HI:`NV_XIP_LO] == `NV_XIP_OFF, 3'h0};
      vec_reg      <= {nv_config[`NV_QUAD_BIT], nv_config[`NV_DUAL_BIT], 1'b0,
                       nv_config[`NV_HOLD_BIT], 1'b1,
                       nv_config[`NV_DRV_HI:`NV_DRV_LO]};
    end else if (commit && !target_vec_reg) begin
      vrc_reg <= stage_reg & `VRC_KEEP_MASK;
    end else if (commit && target_vec_reg) begin
      vec_reg <= stage_reg & `VEC_KEEP_MASK;
    end
  end

  // remember whether the last instruction was a quad program
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qprog_reg <= 1'b0;
    end else if (instr_valid && state_reg == ST_IDLE && !cs_n_s) begin
      qprog_reg <= is_quad_prog;
    end
  end

  assign dummy_code = vrc_reg[`VRC_DUMMY_HI:`VRC_DUMMY_LO];

  // read config decode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dummy_cycles         <= `DUMMY_DEFAULT;
      xip_ready            <= BASIC_XIP;
      volatile_read_config <= `VRC_RESET;
    end else begin
      dummy_cycles <= (dummy_code == `DUMMY_CODE_ZERO) ? `DUMMY_DEFAULT : dummy_code;
      xip_ready    <= BASIC_XIP || !vrc_reg[`VRC_XIP_BIT];
      volatile_read_config <= vrc_reg;
    end
  end

  // dummy clocks after fast read address phase
  dummy_counter u_dummy_counter (
    .clk        (clk),
    .resetn     (resetn),
    .start      ((state_reg == ST_READ) && addr_done),
    .tick       (sclk_rise),
    .abort      (cs_rise),
    .count      (dummy_cycles),
    .active     (cnt_active),
    .first_tick (cnt_first),
    .done       (cnt_done)
  );

  // dummy phase status and line zero capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dummy_phase      <= 1'b0;
      read_data_start  <= 1'b0;
      xip_sample_valid <= 1'b0;
      xip_line_value   <= 1'b1;
    end else begin
      dummy_phase      <= cnt_active;
      read_data_start  <= cnt_done;
      xip_sample_valid <= cnt_first && xip_ready;
      if (cnt_first && xip_ready) begin
        xip_line_value <= dq0_s;
      end
    end
  end

  // enhanced config decode; quad wins over dual
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      protocol                 <= PROTO_EXTENDED;
      hold_enable              <= 1'b1;
      accel_enable             <= 1'b0;
      drive_code               <= `DRV_CODE_30;
      volatile_enhanced_config <= `VEC_RESET;
    end else begin
      if (!vec_reg[`VEC_QUAD_BIT]) begin
        protocol <= PROTO_QUAD;
      end else if (!vec_reg[`VEC_DUAL_BIT]) begin
        protocol <= PROTO_DUAL;
      end else begin
        protocol <= PROTO_EXTENDED;
      end
      hold_enable  <= vec_reg[`VEC_HOLD_BIT];
      accel_enable <= !vec_reg[`VEC_ACCEL_BIT] &&
                      (qprog_reg || !vec_reg[`VEC_QUAD_BIT]);
      drive_code   <= vec_reg[`VEC_DRV_HI:`VEC_DRV_LO];
      volatile_enhanced_config <= vec_reg;
    end
  end

  // driver impedance lookup
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive_ohms     <= `DRV_OHMS_30;
      drive_reserved <= 1'b0;
    end else begin
      drive_reserved <= 1'b0;
      case (vec_reg[`VEC_DRV_HI:`VEC_DRV_LO])
        `DRV_CODE_60: drive_ohms <= `DRV_OHMS_60;
        `DRV_CODE_45: drive_ohms <= `DRV_OHMS_45;
        `DRV_CODE_20: drive_ohms <= `DRV_OHMS_20;
        `DRV_CODE_15: drive_ohms <= `DRV_OHMS_15;
        `DRV_CODE_30: drive_ohms <= `DRV_OHMS_30;
        default: begin
          drive_ohms     <= `DRV_OHMS_NONE;
          drive_reserved <= 1'b1;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_por_dummy_load: assert property (!por_done_reg |=>
    vrc_reg[`VRC_DUMMY_HI:`VRC_DUMMY_LO] == $past(nv_config[`NV_DUMMY_HI:`NV_DUMMY_LO]))
    else $error("power-on dummy load wrong");
  a_vrc_commit: assert property (por_done_reg && commit && !target_vec_reg |=>
    vrc_reg == ($past(stage_reg) & `VRC_KEEP_MASK) ##1 volatile_read_config == $past(vrc_reg))
    else $error("read config write not applied");
  a_vec_commit: assert property (por_done_reg && commit && target_vec_reg |=>
    vec_reg == ($past(stage_reg) & `VEC_KEEP_MASK))
    else $error("enhanced config write not applied");
  a_dummy_map: assert property (dummy_code != `DUMMY_CODE_ZERO |=>
    dummy_cycles == $past(dummy_code))
    else $error("dummy count mismatch");
  a_dummy_zero: assert property (dummy_code == `DUMMY_CODE_ZERO |=>
    dummy_cycles == `DUMMY_DEFAULT)
    else $error("dummy code zero not fifteen");
  a_xip_gate: assert property (vrc_reg[`VRC_XIP_BIT] |=> xip_ready == BASIC_XIP)
    else $error("xip not gated");
  a_dq0_sample: assert property (cnt_first && xip_ready |=>
    xip_sample_valid && xip_line_value == $past(dq0_s))
    else $error("line zero not sampled");
  a_read_arm: assert property (state_reg == ST_IDLE && instr_valid && !cs_n_s &&
    por_done_reg && is_fast_read |=> state_reg == ST_READ)
    else $error("fast read not tracked");
  a_quad_prec: assert property (!vec_reg[`VEC_QUAD_BIT] |=> protocol == PROTO_QUAD)
    else $error("quad lacks precedence");
  a_dual_sel: assert property (vec_reg[`VEC_QUAD_BIT] && !vec_reg[`VEC_DUAL_BIT] |=>
    protocol == PROTO_DUAL)
    else $error("dual not selected");
  a_hold_ctrl: assert property (##1 hold_enable == $past(vec_reg[`VEC_HOLD_BIT]))
    else $error("hold enable mismatch");
  a_accel_off: assert property (vec_reg[`VEC_ACCEL_BIT] |=> !accel_enable)
    else $error("accelerator not disabled");
  a_accel_scope: assert property (vec_reg[`VEC_QUAD_BIT] && !qprog_reg |=>
    !accel_enable)
    else $error("accelerator outside quad scope");
  a_drive_map: assert property (##1 drive_code == $past(vec_reg[2:0]))
    else $error("drive code mismatch");

endmodule : flash_volcfg

/* File: dv/spi_host_model.sv */
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic       clk,                // system clock
  output logic            instr_valid,        // opcode strobe
  output logic [7:0]      instr_code,         // decoded opcode
  output logic            data_valid,         // data byte strobe
  output logic [7:0]      data_byte,          // data byte
  output logic            addr_done,          // address phase over
  output logic            sclk_pin,           // serial clock, idle low
  output logic            chip_select_n,      // chip select, active low
  output logic            serial_io_line_zero // data line zero
);
  // idle bus: deselected, clock parked low
  initial begin
    instr_valid         = 1'b0;
    instr_code          = 8'h00;
    data_valid          = 1'b0;
    data_byte           = 8'h00;
    addr_done           = 1'b0;
    sclk_pin            = 1'b0;
    chip_select_n       = 1'b1;
    serial_io_line_zero = 1'b1;
  end

  // select, let the pin synchroniser settle, then hand over the opcode
  task automatic open_frame(input logic [7:0] op);
    @(posedge clk);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge clk);
    instr_valid <= 1'b1;
    instr_code  <= op;
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask : open_frame

  // deselect and leave room for the commit
  task automatic close_frame;
    chip_select_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : close_frame

  // one register write; without data it must be dropped
  task automatic write_cfg(input logic [7:0] op, input logic [7:0] val, input bit with_data);
    open_frame(op);
    if (with_data) begin
      data_valid <= 1'b1;
      data_byte  <= val;
      @(posedge clk);
      data_valid <= 1'b0;
      data_byte  <= ~val;
    end
    @(posedge clk);
    close_frame();
  endtask : write_cfg

  // fast read: slow serial clock so every dummy count is safe
  task automatic fast_read(input logic [7:0] op, input int rises, input logic line);
    open_frame(op);
    addr_done           <= 1'b1;
    serial_io_line_zero <= line;
    @(posedge clk);
    addr_done <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < rises; i++) begin
      sclk_pin <= 1'b1;
      repeat (8) @(posedge clk);
      sclk_pin <= 1'b0;
      if (i == 0) serial_io_line_zero <= ~line; // hold over: show the inverse
      repeat (8) @(posedge clk);
    end
    close_frame();
  endtask : fast_read
endmodule : spi_host_model

/* File: dv/flash_volcfg_tb_top.sv */
`timescale 1ns/1ps

module flash_volcfg_tb_top;
  import flash_volcfg_pkg::*;
  localparam logic [7:0] wr_rc = 8'h31;
  localparam logic [7:0] wr_ec = 8'h32;
  localparam logic [7:0] pg_q  = 8'h33;
  localparam logic [7:0] rd_ops [6] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46};

  logic clk, resetn, instr_valid, data_valid, addr_done, sclk_pin, chip_select_n, line0;
  logic [15:0] nv_config;
  logic [7:0]  instr_code, data_byte, vrc, vec;
  logic [3:0]  dummy_cycles;
  logic [2:0]  drive_code;
  logic [5:0]  drive_ohms;
  logic dummy_phase, read_data_start, xip_ready, xip_sample_valid, xip_line_value;
  logic hold_enable, accel_enable, drive_reserved, saw_phase;
  proto_t protocol;
  int err_total, n_compared, cyc, rise_cnt;
  int exp_rises[$];
  logic exp_line[$];

  flash_volcfg #(.OP_WR_VRC(wr_rc), .OP_WR_VEC(wr_ec), .OP_RD_SINGLE(rd_ops[0]),
    .OP_RD_DOUT(rd_ops[1]), .OP_RD_DIO(rd_ops[2]), .OP_RD_QOUT(rd_ops[3]),
    .OP_RD_QIO(rd_ops[4]), .OP_RD_OTP(rd_ops[5]), .OP_PG_QUAD(pg_q)) u_flash_volcfg (
    .clk(clk), .resetn(resetn), .nv_config(nv_config), .instr_valid(instr_valid),
    .instr_code(instr_code), .data_valid(data_valid), .data_byte(data_byte),
    .addr_done(addr_done), .sclk_pin(sclk_pin), .chip_select_n(chip_select_n),
    .serial_io_line_zero(line0), .volatile_read_config(vrc),
    .volatile_enhanced_config(vec), .dummy_cycles(dummy_cycles),
    .dummy_phase(dummy_phase), .read_data_start(read_data_start), .xip_ready(xip_ready),
    .xip_sample_valid(xip_sample_valid), .xip_line_value(xip_line_value),
    .protocol(protocol), .hold_enable(hold_enable), .accel_enable(accel_enable),
    .drive_code(drive_code), .drive_ohms(drive_ohms), .drive_reserved(drive_reserved));

  spi_host_model u_spi_host_model (
    .clk(clk), .instr_valid(instr_valid), .instr_code(instr_code),
    .data_valid(data_valid), .data_byte(data_byte), .addr_done(addr_done),
    .sclk_pin(sclk_pin), .chip_select_n(chip_select_n), .serial_io_line_zero(line0));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg

  // pulse results share the register comparison
  task automatic chk_evt(input logic [7:0] got, input logic [7:0] exp, input string what);
    chk_reg(got, exp, what);
  endtask : chk_evt

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // dummy clocks seen on the pin since the address phase ended
  always @(posedge sclk_pin) rise_cnt++;
  always @(posedge clk) if (addr_done) rise_cnt = 0;

  // result watcher: oldest note is compared when a pulse appears
  always @(posedge clk) begin
    if (dummy_phase === 1'b1) saw_phase = 1'b1;
    if (read_data_start === 1'b1) begin
      if (exp_rises.size() == 0) chk_evt(8'h01, 8'h00, "unexpected read start");
      else chk_evt(8'(rise_cnt), 8'(exp_rises.pop_front()), "dummy clocks");
    end
    if (xip_sample_valid === 1'b1) begin
      if (exp_line.size() == 0) chk_evt(8'h01, 8'h00, "unexpected line sample");
      else chk_evt(8'(xip_line_value), 8'(exp_line.pop_front()), "line zero");
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("MISMATCH %0t timeout", $time);
      tally_and_finish();
    end
  end

  function automatic logic [7:0] ohms(input logic [2:0] c);
    case (c)
      3'h2: ohms = 8'h3C;
      3'h3: ohms = 8'h2D;
      3'h5: ohms = 8'h14;
      3'h6: ohms = 8'h0F;
      3'h7: ohms = 8'h1E;
      default: ohms = 8'h00;
    endcase
  endfunction : ohms

  initial begin
    logic [7:0] v;
    logic [7:0] p;
    logic x;
    logic ln;
    logic [7:0] tbl [8] = '{8'hDF, 8'h52, 8'h83, 8'h15, 8'h8E, 8'hD0, 8'h4C, 8'hC9};
    resetn    = 1'b0;
    nv_config = 16'h5EBB;
    void'($urandom(34));
    repeat (10) @(posedge clk);
    chk_reg(vrc, 8'hF8, "read config at reset");
    chk_reg(vec, 8'hDF, "enhanced config at reset");
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk_reg(8'(dummy_cycles), 8'h05, "power-on dummy");
    chk_reg(vrc, 8'h58, "power-on read config");
    chk_reg(vec, 8'h9A, "power-on enhanced");
    chk_reg(8'(protocol), 8'(PROTO_DUAL), "power-on protocol");
    $display("test power_on done");
    // every dummy code, reads rotate over all six read opcodes
    for (int c = 0; c < 16; c++) begin
      x  = 1'($urandom);
      ln = 1'($urandom);
      u_spi_host_model.write_cfg(wr_rc, {4'(c), x, 3'h0}, 1'b1);
      chk_reg(vrc, {4'(c), x, 3'h0}, "read config");
      chk_reg(8'(dummy_cycles), (c == 0) ? 8'h0F : 8'(c), "dummy count");
      chk_reg(8'(xip_ready), {7'h0, ~x}, "xip ready");
      exp_rises.push_back((c == 0) ? 15 : c);
      if (!x) exp_line.push_back(ln);
      u_spi_host_model.fast_read(rd_ops[c % 6], (c == 0) ? 15 : c, ln);
    end
    $display("test dummy_codes done");
    // deselect in mid dummy phase: no read data start
    saw_phase = 1'b0;
    u_spi_host_model.write_cfg(wr_rc, 8'h88, 1'b1);
    u_spi_host_model.fast_read(rd_ops[0], 3, 1'b0);
    chk_reg(8'(saw_phase), 8'h01, "dummy phase seen");
    chk_reg(8'(dummy_phase), 8'h00, "dummy phase after abort");
    $display("test abort done");
    // enhanced config table: protocols, hold, accelerator, all driver codes
    foreach (tbl[i]) begin
      v = tbl[i];
      p = !v[7] ? 8'(PROTO_QUAD) : (!v[6] ? 8'(PROTO_DUAL) : 8'(PROTO_EXTENDED));
      u_spi_host_model.write_cfg(wr_ec, v, 1'b1);
      chk_reg(vec, v, "enhanced config");
      chk_reg(8'(protocol), p, "protocol");
      chk_reg(8'(hold_enable), 8'(v[4]), "hold enable");
      chk_reg(8'(accel_enable), 8'(!v[3] && !v[7]), "accelerator");
      chk_reg(8'(drive_code), 8'(v[2:0]), "drive code");
      chk_reg(8'(drive_ohms), ohms(v[2:0]), "drive ohms");
      chk_reg(8'(drive_reserved), 8'(ohms(v[2:0]) == 8'h00), "drive reserved");
    end
    u_spi_host_model.write_cfg(wr_ec, 8'h5F, 1'b0);
    chk_reg(vec, 8'hC9, "write without data");
    // accelerator outside quad protocol: only after a quad program
    u_spi_host_model.write_cfg(wr_ec, 8'hD0, 1'b1);
    u_spi_host_model.write_cfg(pg_q, 8'h00, 1'b0);
    chk_reg(8'(accel_enable), 8'h01, "accelerator after quad program");
    u_spi_host_model.write_cfg(wr_ec, 8'hD0, 1'b1);
    chk_reg(8'(accel_enable), 8'h00, "accelerator after plain write");
    $display("test enhanced done");
    repeat (20) @(posedge clk);
    chk_reg(8'(exp_rises.size() + exp_line.size()), 8'h00, "missing pulses");
    tally_and_finish();
  end
endmodule : flash_volcfg_tb_top
